// file: logic/adc_postproc_defines.vh
// constants for the converter post-processing block
// assumes a 20 MHz ref_clk and a 32-bit AXI4-Lite register bus
`ifndef ADC_POSTPROC_DEFINES_VH
`define ADC_POSTPROC_DEFINES_VH

// clock rate and conversion time
`define CLK_FREQ_MHZ      20
`define CONV_TIME_NS      500
`define CONV_CYCLES       ((`CONV_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)

// register byte offsets
`define REG_CONTROL       8'h00
`define REG_OFFSET0       8'h04
`define REG_OFFSET1       8'h08
`define REG_GAIN0         8'h0c
`define REG_GAIN1         8'h10
`define REG_STATUS        8'h14
`define REG_RESULT0       8'h18
`define REG_RESULT1       8'h1c

// control field positions
`define CTL_OFFSET_EN     0
`define CTL_GAIN_EN       1
`define CTL_AVG_EN        2
`define CTL_FMT_LO        4
`define CTL_FMT_HI        6

// reset values
`define CONTROL_RESET     7'h00
`define OFFSET_RESET      16'h0000
`define GAIN_RESET        16'h8000

// output formats
`define FMT_DIFF_ONLY     3'h0
`define FMT_DIFF_CM       3'h1

// code limits
`define DIFF_MAX          16'h7fff
`define DIFF_MIN          16'h8000
`define CM_MAX            8'hff
`define GAIN_SHIFT        15

// bus responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// file: logic/dual_adc_conversion_postproc.v
// digital side of a dual simultaneous-sampling converter: start, busy,
// offset/gain with one saturation, common-mode append, result FIFO, serial readout
// assumes raw codes from the converter core on ref_clk and a host SCK well below ref_clk
// Function
// - a conversion begins on each rising edge of the start input; an edge that arrives while busy is high is ignored
// - busy rises on the start edge and falls when conversion completes; a full result FIFO keeps busy high until space frees
// - each conversion yields a 16-bit difference and 8-bit common-mode code
// - processed result is pushed into the result FIFO feeding the serial lanes, and latched into the result registers read over the bus
// - result belongs to the sample taken at that same start edge
// - difference code is signed twos complement, one step per LSB
// - codes 7fff, 0000, ffff, 8000 map full scale, zero, minus one, minus full
// - first conversion after power-down is valid, no dummy conversions
// - raw result clamps to code range end before digital processing
// - after offset and gain, result clamps to 7fff or 8000
// - format 1 appends the common-mode code to the difference code
// - common-mode step is vref/256, clamped to 0 and 255
// - offset and gain never touch the common-mode code
// - offset, gain and averaging each switched by configuration bits; the averaging bit is stored but no averaging is done
// - each channel adds its own signed offset, reset zero
// - each channel multiplies by unsigned gain over 8000, reset unity
// - one output format applies to both channels
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "adc_postproc_defines.vh"

// result buffer between conversion and serial readout
module result_fifo #(
   parameter WIDTH = 49,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] wrData,
   input  wire             wrValid,
   output wire             wrReady,
   output wire [WIDTH-1:0] rdData,
   output wire             rdValid,
   input  wire             rdReady,
   output wire [AW:0]      count
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wrPtr_q;
   reg [AW-1:0]    rdPtr_q;
   reg [AW:0]      count_q;
   wire            push;
   wire            pop;
   localparam [AW:0] FULL_COUNT = DEPTH[AW:0];

   // honest full and empty from the fill count
   assign wrReady = (count_q != FULL_COUNT);
   assign rdValid = (count_q != {(AW+1){1'b0}});
   assign push    = wrValid & wrReady;
   assign pop     = rdValid & rdReady;
   assign rdData  = mem[rdPtr_q];
   assign count   = count_q;

   // storage has no reset, only pointers and count do
   always @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q] <= wrData;
      end
   end

   // pointers and count
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         if (push & ~pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop & ~push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule // result_fifo

module dual_adc_conversion_postproc #(
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW    = 5
) (
   input  wire               ref_clk,
   input  wire               rst,
   input  wire               conversionStart,
   input  wire signed [17:0] rawDiff0,
   input  wire signed [17:0] rawDiff1,
   input  wire signed [9:0]  rawCm0,
   input  wire signed [9:0]  rawCm1,
   output reg                busy,
   input  wire               serialClk,
   input  wire               chipSelN,
   output reg                serialDataOut0,
   output reg                serialDataOut1,
   input  wire [7:0]         s_axi_awaddr,
   input  wire               s_axi_awvalid,
   output reg                s_axi_awready,
   input  wire [31:0]        s_axi_wdata,
   input  wire [3:0]         s_axi_wstrb,
   input  wire               s_axi_wvalid,
   output reg                s_axi_wready,
   output reg  [1:0]         s_axi_bresp,
   output reg                s_axi_bvalid,
   input  wire               s_axi_bready,
   input  wire [7:0]         s_axi_araddr,
   input  wire               s_axi_arvalid,
   output reg                s_axi_arready,
   output reg  [31:0]        s_axi_rdata,
   output reg  [1:0]         s_axi_rresp,
   output reg                s_axi_rvalid,
   input  wire               s_axi_rready
);
   localparam integer CONV_LAST_I = `CONV_CYCLES - 1;
   localparam [7:0]   CONV_LAST   = CONV_LAST_I[7:0];
   localparam       WORD_W    = 49;

   // saturate a wide signed value to the 16-bit code range
   function [15:0] sat16;
      input signed [35:0] v;
      begin
         if (v > 36'sd32767) begin
            sat16 = `DIFF_MAX;
         end else if (v < -36'sd32768) begin
            sat16 = `DIFF_MIN;
         end else begin
            sat16 = v[15:0];
         end
      end
   endfunction

   // offset then gain at full width, one clamp at the end
   function [15:0] procDiff;
      input signed [15:0] code;
      input signed [15:0] off;
      input [15:0]        gain;
      input               offEn;
      input               gainEn;
      reg signed [18:0]   sum;
      reg signed [35:0]   prod;
      reg signed [35:0]   scaled;
      begin
         sum = {{3{code[15]}}, code};
         if (offEn) begin
            sum = sum + {{3{off[15]}}, off};
         end
         prod   = sum * $signed({1'b0, gain});
         scaled = {{17{sum[18]}}, sum};
         if (gainEn) begin
            scaled = prod >>> `GAIN_SHIFT;
         end
         procDiff = sat16(scaled);
      end
   endfunction

   // common-mode code clamped to 0..255
   function [7:0] cmClamp;
      input signed [9:0] v;
      begin
         if (v < 10'sd0) begin
            cmClamp = 8'h00;
         end else if (v > 10'sd255) begin
            cmClamp = `CM_MAX;
         end else begin
            cmClamp = v[7:0];
         end
      end
   endfunction

   // byte-lane merge for register writes
   function [31:0] mergeStrb;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  strb;
      integer      i;
      begin
         mergeStrb = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               mergeStrb[i*8 +: 8] = data[i*8 +: 8];
            end
         end
      end
   endfunction

   reg  [6:0]        control_q;
   reg  [15:0]       offset0_q;
   reg  [15:0]       offset1_q;
   reg  [15:0]       gain0_q;
   reg  [15:0]       gain1_q;
   reg  [31:0]       result0_q;
   reg  [31:0]       result1_q;
   reg  [2:0]        convSync_q;
   reg  [2:0]        sckSync_q;
   reg  [2:0]        csSync_q;
   reg  [7:0]        convCnt_q;
   reg  [15:0]       sampDiff0_q;
   reg  [15:0]       sampDiff1_q;
   reg  [7:0]        sampCm0_q;
   reg  [7:0]        sampCm1_q;
   reg  [23:0]       shift0_q;
   reg  [23:0]       shift1_q;
   reg               awHeld_q;
   reg               wHeld_q;
   reg  [7:0]        awAddr_q;
   reg  [31:0]       wData_q;
   reg  [3:0]        wStrb_q;
   reg  [31:0]       rdMux;
   reg               rdErr;
   wire              convEdge;
   wire              sckFall;
   wire              csFall;
   wire              csLow;
   wire              convDone;
   wire              fifoWrReady;
   wire              fifoRdValid;
   wire [WORD_W-1:0] fifoIn;
   wire [WORD_W-1:0] fifoOut;
   wire [FIFO_AW:0]  fifoCount;
   wire [15:0]       procDiff0;
   wire [15:0]       procDiff1;
   wire              fmtCm;
   wire [31:0]       mrgCtl;
   wire [31:0]       mrgOff0;
   wire [31:0]       mrgOff1;
   wire [31:0]       mrgGain0;
   wire [31:0]       mrgGain1;

   // pins pass two flops, third flop keeps the previous level for edges
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         convSync_q <= 3'h0;
         sckSync_q  <= 3'h0;
         csSync_q   <= 3'h7;
      end else begin
         convSync_q <= {convSync_q[1:0], conversionStart};
         sckSync_q  <= {sckSync_q[1:0], serialClk};
         csSync_q   <= {csSync_q[1:0], chipSelN};
      end
   end

   assign convEdge = convSync_q[1] & ~convSync_q[2];
   assign sckFall  = ~sckSync_q[1] & sckSync_q[2];
   assign csFall   = ~csSync_q[1] & csSync_q[2];
   assign csLow    = ~csSync_q[1];
   assign convDone = busy & (convCnt_q == CONV_LAST);

   assign procDiff0 = procDiff(sampDiff0_q, offset0_q, gain0_q,
                               control_q[`CTL_OFFSET_EN], control_q[`CTL_GAIN_EN]);
   assign procDiff1 = procDiff(sampDiff1_q, offset1_q, gain1_q,
                               control_q[`CTL_OFFSET_EN], control_q[`CTL_GAIN_EN]);

   // one format bit for both lanes
   assign fmtCm  = (control_q[`CTL_FMT_HI:`CTL_FMT_LO] == `FMT_DIFF_CM);
   assign fifoIn = {fmtCm, procDiff0, sampCm0_q, procDiff1, sampCm1_q};

   // conversion sequencer; a full FIFO holds busy high until space frees
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy        <= 1'b0;
         convCnt_q   <= 8'h00;
         sampDiff0_q <= 16'h0000;
         sampDiff1_q <= 16'h0000;
         sampCm0_q   <= 8'h00;
         sampCm1_q   <= 8'h00;
         result0_q   <= 32'h00000000;
         result1_q   <= 32'h00000000;
      end else begin
         if (convEdge & ~busy) begin
            busy      <= 1'b1;
            convCnt_q <= 8'h00;
            sampDiff0_q <= sat16({{18{rawDiff0[17]}}, rawDiff0});
            sampDiff1_q <= sat16({{18{rawDiff1[17]}}, rawDiff1});
            sampCm0_q <= cmClamp(rawCm0);
            sampCm1_q <= cmClamp(rawCm1);
         end else if (busy & ~convDone) begin
            convCnt_q <= convCnt_q + 8'h01;
         end
         if (convDone & fifoWrReady) begin
            busy      <= 1'b0;
            result0_q <= {8'h00, procDiff0, sampCm0_q};
            result1_q <= {8'h00, procDiff1, sampCm1_q};
         end
      end
   end

   result_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk     (ref_clk),
      .rst     (rst),
      .wrData  (fifoIn),
      .wrValid (convDone),
      .wrReady (fifoWrReady),
      .rdData  (fifoOut),
      .rdValid (fifoRdValid),
      .rdReady (csFall),
      .count   (fifoCount)
   );

   // output shift registers, loaded at frame start, shifted on SCK falling
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shift0_q       <= 24'h000000;
         shift1_q       <= 24'h000000;
         serialDataOut0 <= 1'b0;
         serialDataOut1 <= 1'b0;
      end else begin
         if (csFall) begin
            if (fifoRdValid & fifoOut[48]) begin
               shift0_q <= fifoOut[47:24];
               shift1_q <= fifoOut[23:0];
            end else if (fifoRdValid) begin
               shift0_q <= {fifoOut[47:32], 8'h00};
               shift1_q <= {fifoOut[23:8], 8'h00};
            end else begin
               shift0_q <= 24'h000000; // empty buffer reads zero
               shift1_q <= 24'h000000;
            end
         end else if (csLow & sckFall) begin
            shift0_q <= {shift0_q[22:0], 1'b0};
            shift1_q <= {shift1_q[22:0], 1'b0};
         end
         serialDataOut0 <= csLow & shift0_q[23];
         serialDataOut1 <= csLow & shift1_q[23];
      end
   end

   // pending write merged into each register's old value, cut to width on store
   assign mrgCtl   = mergeStrb({25'h0, control_q}, wData_q, wStrb_q);
   assign mrgOff0  = mergeStrb({16'h0, offset0_q}, wData_q, wStrb_q);
   assign mrgOff1  = mergeStrb({16'h0, offset1_q}, wData_q, wStrb_q);
   assign mrgGain0 = mergeStrb({16'h0, gain0_q}, wData_q, wStrb_q);
   assign mrgGain1 = mergeStrb({16'h0, gain1_q}, wData_q, wStrb_q);

   // write side: address and data taken in either order
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         awHeld_q      <= 1'b0;
         wHeld_q       <= 1'b0;
         awAddr_q      <= 8'h00;
         wData_q       <= 32'h00000000;
         wStrb_q       <= 4'h0;
         control_q     <= `CONTROL_RESET;
         offset0_q     <= `OFFSET_RESET;
         offset1_q     <= `OFFSET_RESET;
         gain0_q       <= `GAIN_RESET;
         gain1_q       <= `GAIN_RESET;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awAddr_q      <= s_axi_awaddr;
            awHeld_q      <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wData_q      <= s_axi_wdata;
            wStrb_q      <= s_axi_wstrb;
            wHeld_q      <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (awHeld_q & wHeld_q & ~s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `RESP_OKAY;
            if (awAddr_q == `REG_CONTROL) begin
               control_q <= mrgCtl[6:0] & 7'h77;
            end else if (awAddr_q == `REG_OFFSET0) begin
               offset0_q <= mrgOff0[15:0];
            end else if (awAddr_q == `REG_OFFSET1) begin
               offset1_q <= mrgOff1[15:0];
            end else if (awAddr_q == `REG_GAIN0) begin
               gain0_q <= mrgGain0[15:0];
            end else if (awAddr_q == `REG_GAIN1) begin
               gain1_q <= mrgGain1[15:0];
            end else if ((awAddr_q == `REG_STATUS) | (awAddr_q == `REG_RESULT0) |
                         (awAddr_q == `REG_RESULT1)) begin
               s_axi_bresp <= `RESP_OKAY; // read-only, write ignored
            end else begin
               s_axi_bresp <= `RESP_SLVERR;
            end
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // read decode; status shows busy and buffer state
   always @* begin
      rdMux = 32'h00000000;
      rdErr = 1'b0;
      if (s_axi_araddr == `REG_CONTROL) begin
         rdMux = {25'h0, control_q};
      end else if (s_axi_araddr == `REG_OFFSET0) begin
         rdMux = {16'h0, offset0_q};
      end else if (s_axi_araddr == `REG_OFFSET1) begin
         rdMux = {16'h0, offset1_q};
      end else if (s_axi_araddr == `REG_GAIN0) begin
         rdMux = {16'h0, gain0_q};
      end else if (s_axi_araddr == `REG_GAIN1) begin
         rdMux = {16'h0, gain1_q};
      end else if (s_axi_araddr == `REG_STATUS) begin
         rdMux = {16'h0, 2'h0, fifoCount, ~fifoWrReady, ~fifoRdValid, 5'h0, busy};
      end else if (s_axi_araddr == `REG_RESULT0) begin
         rdMux = result0_q;
      end else if (s_axi_araddr == `REG_RESULT1) begin
         rdMux = result1_q;
      end else begin
         rdErr = 1'b1;
      end
   end

   // read channel, answer one cycle after the address is taken
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdMux;
            s_axi_rresp   <= rdErr ? `RESP_SLVERR : `RESP_OKAY;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // dual_adc_conversion_postproc

// file: test/dual_adc_conversion_postproc_properties.sv
// port-level checker for the converter post-processing block
// bound from the bench top file; sees only the top module's ports
`timescale 1ns/100ps
`include "adc_postproc_defines.vh"
module dual_adc_conversion_postproc_properties #(
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW    = 5
) (
   input wire        ref_clk,
   input wire        rst,
   input wire        conversionStart,
   input wire        busy,
   input wire        chipSelN,
   input wire        serialDataOut0,
   input wire        serialDataOut1,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready
);
   // one clock domain, so clocking and disable are given once
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_busyRise;
      $rose(conversionStart) && !busy |-> ##[1:5] busy;
   endproperty
   a_busyRise: assert property (p_busyRise) else $error("start edge gave no busy");
   property p_busyCause;
      $rose(busy) |-> $past(conversionStart, 2);
   endproperty
   a_busyCause: assert property (p_busyCause) else $error("busy rose without start");
   // run length of busy, counted so no long repetition is unrolled
   int busyLen_q;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busyLen_q <= 0;
      end else if (busy) begin
         busyLen_q <= busyLen_q + 1;
      end else begin
         busyLen_q <= 0;
      end
   end
   // full buffer may stretch busy, so only the minimum is fixed
   property p_busyHold;
      $fell(busy) |-> busyLen_q >= `CONV_CYCLES;
   endproperty
   a_busyHold: assert property (p_busyHold) else $error("busy shorter than conversion");
   property p_bHold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bHold: assert property (p_bHold) else $error("write response dropped");
   property p_rHold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rHold: assert property (p_rHold) else $error("read response dropped");
   property p_arTake;
      s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##[0:1] s_axi_rvalid;
   endproperty
   a_arTake: assert property (p_arTake) else $error("read not answered");
   property p_rdErr;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1f
         |-> ##[1:2] s_axi_rvalid && s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_rdErr: assert property (p_rdErr) else $error("unmapped read not refused");
   // lanes rest low once the deselect has passed the synchronisers
   property p_laneIdle;
      chipSelN [*5] |-> !serialDataOut0 && !serialDataOut1;
   endproperty
   a_laneIdle: assert property (p_laneIdle) else $error("lane driven while idle");
endmodule // dual_adc_conversion_postproc_properties

// file: test/host_model.sv
// host controller model: start pulses and two-lane serial readout
// assumes shifting on SCK fall; lanes are sampled at SCK rise
`timescale 1ns/100ps
module host_model (
   input  wire logic ref_clk,
   input  wire logic serialDataOut0,
   input  wire logic serialDataOut1,
   output logic      conversionStart,
   output logic      serialClk,
   output logic      chipSelN
);
   // idle levels; SCK stands low outside frames
   initial begin
      conversionStart = 1'h0;
      serialClk = 1'h0;
      chipSelN = 1'h1;
   end
   task automatic pulseStart();
      @(posedge ref_clk);
      conversionStart <= 1'h1;
      repeat (6) @(posedge ref_clk);
      conversionStart <= 1'h0;
   endtask
   // 400 ns SCK: high 3, low 5 cycles, since a lane settles ~4 cycles after SCK falls
   task automatic readFrame(input int nBits, output logic [23:0] w0, output logic [23:0] w1);
      w0 = 24'h0;
      w1 = 24'h0;
      @(posedge ref_clk);
      chipSelN <= 1'h0;
      repeat (8) @(posedge ref_clk);
      for (int i = 0; i < nBits; i++) begin
         w0 = {w0[22:0], serialDataOut0};
         w1 = {w1[22:0], serialDataOut1};
         serialClk <= 1'h1;
         repeat (3) @(posedge ref_clk);
         serialClk <= 1'h0;
         repeat (5) @(posedge ref_clk);
      end
      chipSelN <= 1'h1;
      repeat (8) @(posedge ref_clk);
   endtask
endmodule // host_model

// file: test/dual_adc_conversion_postproc_tb_top.sv
// bench for the post-processing block: AXI4-Lite master, core stimulus, host model
// assumes 20 MHz ref_clk; expected codes come from the integer model below
`timescale 1ns/100ps
`include "adc_postproc_defines.vh"
module dual_adc_conversion_postproc_tb_top;
   logic               ref_clk = 1'h0;
   logic               rst = 1'h1;
   logic               conversionStart, serialClk, chipSelN, busy;
   logic               serialDataOut0, serialDataOut1;
   logic signed [17:0] rawDiff0 = 18'h0, rawDiff1 = 18'h0;
   logic signed [9:0]  rawCm0 = 10'h0, rawCm1 = 10'h0;
   logic [7:0]         s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0]        s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]         s_axi_wstrb = 4'hf;
   logic               s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic               s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]         s_axi_bresp, s_axi_rresp;
   logic [6:0]         cfgCtl = 7'h0;
   logic [15:0]        cfgOff0 = 16'h0, cfgOff1 = 16'h0, cfgGain0 = 16'h8000, cfgGain1 = 16'h8000;
   logic [23:0]        q0[$], q1[$];
   int                 qBits[$];
   int                 failCount = 0, comparisons = 0;

   always #25 ref_clk = ~ref_clk;
   dual_adc_conversion_postproc dual_adc_conversion_postproc_i (.*);
   host_model host_model_i (.*);

   task automatic conclude();
      if (failCount == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // each channel released when taken; bready held until the response
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axiWrite(a, d, r);
      checkVal("write resp", {30'h0, `RESP_OKAY}, {30'h0, r});
   endtask
   task automatic regCheck(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      logic [1:0]  r;
      axiRead(a, d, r);
      checkVal(what, exp, d);
      checkVal("read resp", {30'h0, `RESP_OKAY}, {30'h0, r});
   endtask
   // raw clamp, offset before gain, one final clamp; cm bypasses both
   function automatic logic [23:0] model(int raw, int cm, int off, int gain, logic [6:0] ctl);
      longint v;
      v = raw > 32767 ? 32767 : raw < -32768 ? -32768 : raw;
      cm = cm > 255 ? 255 : cm < 0 ? 0 : cm;
      if (ctl[0]) v = v + off;
      if (ctl[1]) v = (v * gain) >>> 15;
      v = v > 32767 ? 32767 : v < -32768 ? -32768 : v;
      return {v[15:0], cm[7:0]};
   endfunction
   // one frame off the buffer head; format 0 carries the difference only
   task automatic drainOne();
      logic [23:0] w0, w1, e0, e1;
      int          n;
      n = qBits.pop_front();
      e0 = q0.pop_front();
      e1 = q1.pop_front();
      host_model_i.readFrame(n, w0, w1);
      if (n == 16) e0 = {8'h0, e0[23:8]};
      if (n == 16) e1 = {8'h0, e1[23:8]};
      checkVal("lane0", {8'h0, e0}, {8'h0, w0});
      checkVal("lane1", {8'h0, e1}, {8'h0, w1});
   endtask
   // k 0 runs on reset config; k 32 hits a full buffer
   task automatic convOne(input int k);
      logic [23:0] e0, e1;
      if (k > 0) begin
         cfgCtl = {3'(k % 8), 1'h0, 3'($urandom)};
         cfgOff0 = 16'($urandom);
         cfgOff1 = 16'($urandom);
         cfgGain0 = 16'($urandom);
         cfgGain1 = 16'($urandom);
         regWrite(`REG_CONTROL, {25'h0, cfgCtl});
         regWrite(`REG_OFFSET0, {16'h0, cfgOff0});
         regWrite(`REG_OFFSET1, {16'h0, cfgOff1});
         regWrite(`REG_GAIN0, {16'h0, cfgGain0});
         regWrite(`REG_GAIN1, {16'h0, cfgGain1});
         regCheck(`REG_CONTROL, {25'h0, cfgCtl}, "control");
      end
      @(posedge ref_clk);
      rawDiff0 <= (k % 3 == 0) ? 18'($urandom) : 18'($signed(16'($urandom)));
      rawDiff1 <= (k % 3 == 1) ? 18'($urandom) : 18'($signed(16'($urandom)));
      rawCm0 <= 10'($urandom);
      rawCm1 <= 10'($urandom);
      host_model_i.pulseStart();
      if (k == 32) begin
         repeat (30) @(posedge ref_clk);
         checkVal("busy held", 32'h1, {31'h0, busy});
         drainOne();
      end
      while (busy) @(posedge ref_clk);
      e0 = model(rawDiff0, rawCm0, $signed(cfgOff0), cfgGain0, cfgCtl);
      e1 = model(rawDiff1, rawCm1, $signed(cfgOff1), cfgGain1, cfgCtl);
      regCheck(`REG_RESULT0, {8'h0, e0}, "result0");
      regCheck(`REG_RESULT1, {8'h0, e1}, "result1");
      q0.push_back(e0);
      q1.push_back(e1);
      qBits.push_back(cfgCtl[6:4] == `FMT_DIFF_CM ? 24 : 16);
   endtask

   // main sequence: reset values, refusals, fill, overflow, drain
   initial begin
      int          seedTmp;
      logic [31:0] d;
      logic [1:0]  r;
      seedTmp = $urandom(32'hd70275f8);
      repeat (4) @(posedge ref_clk);
      rst <= 1'h0;
      regCheck(`REG_OFFSET1, 32'h0, "offset1");
      regCheck(`REG_GAIN0, 32'h8000, "gain0");
      regCheck(`REG_STATUS, 32'h40, "status");
      axiRead(8'h20, d, r);
      checkVal("unmapped read", {30'h0, `RESP_SLVERR}, {30'h0, r});
      axiWrite(8'h24, 32'h1, r);
      checkVal("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, r});
      for (int k = 0; k < 32; k++) convOne(k);
      regCheck(`REG_STATUS, 32'h2080, "status full");
      convOne(32);
      while (q0.size() > 0) drainOne();
      regCheck(`REG_STATUS, 32'h40, "status empty");
      conclude();
   end
   // cuts a hang short
   initial begin
      #(60000 * 50);
      failCount++;
      conclude();
   end
endmodule // dual_adc_conversion_postproc_tb_top

bind dual_adc_conversion_postproc dual_adc_conversion_postproc_properties #(
   .FIFO_DEPTH(FIFO_DEPTH),
   .FIFO_AW(FIFO_AW)
) props_i (.*);
